// ==== design/eirq_consts.svh ====
// register offsets, bit positions, reset values for the external irq block
`ifndef EIRQ_CONSTS_SVH
`define EIRQ_CONSTS_SVH

`define EIRQ_ADDR_W          4
`define EIRQ_OFF_CTRL_STATUS 4'h0
`define EIRQ_OFF_STATUS      4'h1
`define EIRQ_OFF_MASK        4'h2
`define EIRQ_BIT_PULL_DIS    6
`define EIRQ_BIT_POLARITY    5
`define EIRQ_BIT_PIN_EN      4
`define EIRQ_BIT_PENDING     3
`define EIRQ_BIT_ACK         2
`define EIRQ_BIT_IRQ_EN      1
`define EIRQ_BIT_MODE        0
`define EIRQ_CTRL_RESET      8'h00
`define EIRQ_CTRL_WMASK      8'h73
`define EIRQ_EV_EDGE         0
`define EIRQ_EV_ACK_BLOCKED  1
`define EIRQ_EV_MASK         8'h03

`endif

// ==== design/eirq_pin_logic.sv ====
// external interrupt request pin logic with register port and status irq
// ==========================================================
// How it works
// R1 - pull-disable bit switches pull resistor off
// R2 - polarity bit picks falling or rising events
// R3 - rising detection turns pullup into pulldown
// R4 - pin-enable bit turns pin function on
// R5 - pull resistor on when pin enabled
// R6 - pending flag read-only, shows detected event
// R7 - ack write one clears flag, reads zero
// R8 - level mode: ack blocked while pin asserted
// R9 - irq enable drives cpu request from flag
// R10 - mode bit selects edge or edge-and-level
// R11 - pin synchronised; no flag while disabled
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "eirq_consts.svh"

module eirq_pin_logic
    import eirq_pkg::*;
(
    input  wire logic                      core_clk_i,  // 10 MHz bus clock
    input  wire logic                      reset_n_i,   // async reset, low
    input  wire logic                      irq_pin_i,   // raw pin level
    input  wire logic [`EIRQ_ADDR_W-1:0]   addr_i,      // register address
    input  wire eirq_pkg::eirq_byte_t      wdata_i,     // write data
    input  wire logic                      wr_i,        // write strobe
    input  wire logic                      rd_i,        // read strobe
    output eirq_pkg::eirq_byte_t           rdata_o,     // read data, next cycle
    output logic                           cpu_irq_o,   // cpu irq request
    output logic                           pull_en_o,   // pull resistor on
    output logic                           pull_down_o, // 1 pulldown, 0 pullup
    output logic                           status_irq_o // masked status irq
);
    import eirq_pkg::*;

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [1:0] sync;     // pin synchroniser, [0] first stage
        logic       pin_q;    // previous synchronised level
        eirq_byte_t ctrl;     // control bits, ack/flag kept out
        logic       pending;  // request flag
        eirq_byte_t status;   // sticky event bits
        eirq_byte_t mask;     // status irq mask
        eirq_byte_t rdata;    // read data holding
        logic       cpu_irq;  // registered cpu request
        logic       pull_en;  // registered pull enable
        logic       pull_dn;  // registered pull direction
        logic       st_irq;   // registered status irq
    } eirq_state_t;

    eirq_state_t st_reg;   // current state
    eirq_state_t st_next;  // next state

    logic pin_s;       // synchronised pin
    logic asserted;    // pin at active level
    logic edge_seen;   // active edge this cycle
    logic event_hit;   // qualifying event
    logic ack_wr;      // ack bit written
    logic ack_block;   // ack held off by level
    logic pin_en;      // pin function on
    logic level_mode;  // edge-and-level mode
    logic polarity;    // 1 rising/high

    // control view as read by software; ack reads zero
    function automatic eirq_byte_t ctrl_view(eirq_byte_t c, logic p);
        eirq_byte_t v;
        v = c & `EIRQ_CTRL_WMASK;
        v[`EIRQ_BIT_PENDING] = p;  // R6
        v[`EIRQ_BIT_ACK] = 1'b0;   // R7
        return v;
    endfunction

    // ==========================================================
    // next-state logic
    // ==========================================================
    always_comb
    begin
        st_next = st_reg;
        // only the second stage is read downstream; the first may
        // still be settling after a pin change near the clock edge
        // two stages cost two cycles of latency on every request
        st_next.sync = {st_reg.sync[0], irq_pin_i};  // R11
        pin_s = st_reg.sync[1];
        st_next.pin_q = pin_s;
        pin_en = st_reg.ctrl[`EIRQ_BIT_PIN_EN];             // R4
        level_mode = st_reg.ctrl[`EIRQ_BIT_MODE];           // R10
        polarity = st_reg.ctrl[`EIRQ_BIT_POLARITY];         // R2
        asserted = polarity ? pin_s : ~pin_s;               // R2
        edge_seen = polarity ? (pin_s & ~st_reg.pin_q)
                             : (~pin_s & st_reg.pin_q);     // R2
        // level mode keeps requesting while the pin is held active
        event_hit = pin_en &
            (edge_seen | (level_mode & asserted));          // R10 R11
        ack_wr = wr_i && addr_i == `EIRQ_OFF_CTRL_STATUS
                 && wdata_i[`EIRQ_BIT_ACK];                 // R7
        ack_block = level_mode & asserted & pin_en;         // R8

        // flag: set wins over an acknowledge in the same cycle
        if (event_hit)
        begin
            st_next.pending = 1'b1;                         // R6
        end
        else if (ack_wr && !ack_block)
        begin
            st_next.pending = 1'b0;                         // R7 R8
        end

        // register writes
        if (wr_i)
        begin
            case (addr_i)
                `EIRQ_OFF_CTRL_STATUS:
                begin
                    st_next.ctrl = wdata_i & `EIRQ_CTRL_WMASK;
                end
                `EIRQ_OFF_STATUS:
                begin
                    // write one clears; events below re-set
                    st_next.status = st_reg.status & ~wdata_i;
                end
                `EIRQ_OFF_MASK:
                begin
                    st_next.mask = wdata_i & `EIRQ_EV_MASK;
                end
                default:
                begin
                    // unmapped: ignored
                end
            endcase
        end
        // sticky events, set wins over clear
        if (edge_seen && pin_en)
        begin
            st_next.status[`EIRQ_EV_EDGE] = 1'b1;
        end
        if (ack_wr && ack_block)
        begin
            st_next.status[`EIRQ_EV_ACK_BLOCKED] = 1'b1;
        end

        // read data appear the cycle after the strobe
        st_next.rdata = 8'h00;
        if (rd_i)
        begin
            case (addr_i)
                `EIRQ_OFF_CTRL_STATUS:
                    st_next.rdata = ctrl_view(st_reg.ctrl, st_reg.pending);
                `EIRQ_OFF_STATUS: st_next.rdata = st_reg.status;
                `EIRQ_OFF_MASK:   st_next.rdata = st_reg.mask;
                default:          st_next.rdata = 8'h00;
            endcase
        end

        // outputs, registered from the next state so they change with the state they follow
        st_next.cpu_irq = st_next.pending
                          & st_next.ctrl[`EIRQ_BIT_IRQ_EN];   // R9
        st_next.pull_en = st_next.ctrl[`EIRQ_BIT_PIN_EN]
                          & ~st_next.ctrl[`EIRQ_BIT_PULL_DIS]; // R1 R5
        st_next.pull_dn = st_next.ctrl[`EIRQ_BIT_PIN_EN]
                          & st_next.ctrl[`EIRQ_BIT_POLARITY];  // R3
        st_next.st_irq = |(st_next.status & st_next.mask);
    end

    // ==========================================================
    // state register
    // ==========================================================
    // reset clears the synchroniser too, so the pin reads low for two
    // cycles; harmless, since the pin function is off after reset
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_reg <= '0;
            st_reg.ctrl <= `EIRQ_CTRL_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rdata_o = st_reg.rdata;
    assign cpu_irq_o = st_reg.cpu_irq;
    assign pull_en_o = st_reg.pull_en;
    assign pull_down_o = st_reg.pull_dn;
    assign status_irq_o = st_reg.st_irq;

    // ==========================================================
    // checks
    // ==========================================================
    // outputs are registered from the next state, so they line up
    // with the state register at every edge; a slip shows up here
    property p_irq_follows_flag;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        cpu_irq_o == (st_reg.pending & st_reg.ctrl[`EIRQ_BIT_IRQ_EN]);
    endproperty
    a_irq_follows_flag: assert property (p_irq_follows_flag) // R9
        else $error("cpu irq does not follow flag and enable");

    property p_pull_off;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        st_reg.ctrl[`EIRQ_BIT_PULL_DIS] |-> !pull_en_o;
    endproperty
    a_pull_off: assert property (p_pull_off) // R1
        else $error("pull on while disabled");

    property p_pull_on;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (st_reg.ctrl[`EIRQ_BIT_PIN_EN] & ~st_reg.ctrl[`EIRQ_BIT_PULL_DIS])
        |-> pull_en_o;
    endproperty
    a_pull_on: assert property (p_pull_on) // R5
        else $error("pull off while pin enabled");

    property p_pulldown;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (st_reg.ctrl[`EIRQ_BIT_PIN_EN] & st_reg.ctrl[`EIRQ_BIT_POLARITY])
        |-> pull_down_o;
    endproperty
    a_pulldown: assert property (p_pulldown) // R3
        else $error("rising mode without pulldown");

    property p_no_set_disabled;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (!st_reg.pending && !st_reg.ctrl[`EIRQ_BIT_PIN_EN]) |=>
        !st_reg.pending;
    endproperty
    a_no_set_disabled: assert property (p_no_set_disabled) // R11
        else $error("flag set while pin disabled");

    property p_ack_clears;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (ack_wr && !event_hit && !ack_block) |=> !st_reg.pending;
    endproperty
    a_ack_clears: assert property (p_ack_clears) // R7
        else $error("ack did not clear flag");

    property p_ack_blocked;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (st_reg.pending && ack_block) |=> st_reg.pending;
    endproperty
    a_ack_blocked: assert property (p_ack_blocked) // R8
        else $error("flag cleared while level asserted");

    property p_edge_sets;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (pin_en && edge_seen) |=> st_reg.pending ##1 1'b1;
    endproperty
    a_edge_sets: assert property (p_edge_sets) // R2
        else $error("active edge did not set flag");

    property p_level_sets;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (pin_en && level_mode && asserted) |=> st_reg.pending;
    endproperty
    a_level_sets: assert property (p_level_sets) // R10
        else $error("held level did not set flag");

    property p_ack_reads_zero;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (rd_i && addr_i == `EIRQ_OFF_CTRL_STATUS) |=>
        (!rdata_o[`EIRQ_BIT_ACK]
         && rdata_o[`EIRQ_BIT_PENDING] == $past(st_reg.pending));
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero) // R6
        else $error("control read shows wrong ack or flag");

    property p_pin_en_gates;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !pin_en |-> !event_hit;
    endproperty
    a_pin_en_gates: assert property (p_pin_en_gates) // R4
        else $error("event while pin function off");

    // falling sense keeps the pull as a pullup
    property p_pullup_falling;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !st_reg.ctrl[`EIRQ_BIT_POLARITY] |-> !pull_down_o;
    endproperty
    a_pullup_falling: assert property (p_pullup_falling) // R3
        else $error("falling mode without pullup");

    // pin function off: no pull device of either kind
    property p_pin_off_no_pull;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !st_reg.ctrl[`EIRQ_BIT_PIN_EN] |-> !(pull_en_o | pull_down_o);
    endproperty
    a_pin_off_no_pull: assert property (p_pin_off_no_pull) // R4
        else $error("pull active while pin function off");

    // edge-only mode: a held level alone never raises the flag
    property p_edge_only_no_level;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (pin_en && !level_mode && !edge_seen && !st_reg.pending)
        |=> !st_reg.pending;
    endproperty
    a_edge_only_no_level: assert property (p_edge_only_no_level) // R10
        else $error("flag set without edge in edge-only mode");

    // ack and flag bits are never kept in the control store
    property p_ack_not_stored;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        !st_reg.ctrl[`EIRQ_BIT_ACK] && !st_reg.ctrl[`EIRQ_BIT_PENDING];
    endproperty
    a_ack_not_stored: assert property (p_ack_not_stored) // R7
        else $error("ack or flag bit kept in control store");
endmodule // eirq_pin_logic

// ==== design/eirq_pkg.sv ====
// types shared by the external irq pin block
package eirq_pkg;
    typedef logic [7:0] eirq_byte_t;   // one register byte
endpackage

// ==== sim/eirq_pin_logic_tb.sv ====
// self-checking bench for the external irq pin block
`timescale 1ns/100ps
`include "eirq_consts.svh"

module eirq_pin_logic_tb;
    import eirq_pkg::*;
    localparam logic [3:0] a_ct = `EIRQ_OFF_CTRL_STATUS; // ctrl/status
    localparam logic [3:0] a_st = `EIRQ_OFF_STATUS;      // event status
    localparam logic [3:0] a_mk = `EIRQ_OFF_MASK;        // event mask
    logic       clk = 0, rst_n = 0, drv_en = 1, drv_val = 1, pin;
    logic [3:0] addr = 0;              // bus address
    eirq_byte_t wdata = 0, rdata_o, r; // bus data
    logic       wr_s = 0, rd_s = 0, rd_seen = 0;
    logic       cpu_irq_o, pull_en_o, pull_down_o, status_irq_o;
    eirq_byte_t exp_q[$];              // expected read data
    int         n_mismatch = 0, total_checks = 0, i;

    eirq_pin_logic u_dut (.core_clk_i(clk), .reset_n_i(rst_n),
        .irq_pin_i(pin), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
        .rd_i(rd_s), .rdata_o(rdata_o), .cpu_irq_o(cpu_irq_o),
        .pull_en_o(pull_en_o), .pull_down_o(pull_down_o),
        .status_irq_o(status_irq_o));
    eirq_pin_model u_dev (.core_clk_i(clk), .drive_en_i(drv_en),
        .drive_val_i(drv_val), .pull_en_i(pull_en_o),
        .pull_down_i(pull_down_o), .pin_o(pin));

    // ==========================================================
    // clock and helpers
    initial
    begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input eirq_byte_t seen, input eirq_byte_t exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one bus cycle; strobes stay up so calls run back to back
    task automatic bus(input logic w, input logic [3:0] a,
                       input eirq_byte_t d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= w;
        rd_s  <= ~w;
        if (!w)
            exp_q.push_back(d);
    endtask

    // idle cycles, ending at a falling edge for level checks
    task automatic gap(input int n);
        repeat (n)
        begin
            @(posedge clk);
            wr_s <= 1'b0;
            rd_s <= 1'b0;
        end
        @(negedge clk);
    endtask

    // strobes drop here too, so a bus call just before stays one cycle
    task automatic pin_to(input logic v);
        @(posedge clk);
        drv_val <= v;
        wr_s    <= 1'b0;
        rd_s    <= 1'b0;
        gap(6);
    endtask

    // bounded wait for the cpu request
    task automatic wait_irq;
        for (int k = 0; k < 12 && cpu_irq_o !== 1'b1; k++)
            @(negedge clk);
        chk(cpu_irq_o, 1'b1);
        if (cpu_irq_o !== 1'b1)
            report_and_stop;
    endtask

    // ==========================================================
    // read data monitor: oldest note against the answer
    always @(posedge clk)
    begin
        if (rd_seen)
            chk(rdata_o, exp_q.pop_front());
        rd_seen <= rd_s;
    end

    // ==========================================================
    // main sequence
    initial
    begin
        void'($urandom(37));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        gap(1);
        chk(cpu_irq_o | pull_en_o | pull_down_o | status_irq_o, 0);
        bus(0, a_ct, `EIRQ_CTRL_RESET);
        // every pin enable, polarity and pull disable setting
        for (i = 0; i < 8; i++)
        begin
            r = eirq_byte_t'(i) << 4;
            bus(1, a_ct, r);
            gap(1);
            chk(pull_en_o, r[4] & ~r[6]);
            chk(pull_down_o, r[4] & r[5]);
        end
        bus(1, a_ct, 8'h04);
        r = eirq_byte_t'($urandom) & 8'hEF;
        bus(1, a_ct, r);
        pin_to(0);
        pin_to(1);
        bus(0, a_ct, r & 8'h63);
        chk(cpu_irq_o, 0);
        $display("test config done");
        // falling edge, ack, no-op ack write
        bus(1, a_ct, 8'h12);
        gap(2);
        pin_to(0);
        wait_irq();
        bus(0, a_ct, 8'h1A);
        bus(1, a_ct, 8'h12);
        gap(1);
        bus(0, a_ct, 8'h1A);
        bus(1, a_ct, 8'h16);
        gap(1);
        bus(0, a_ct, 8'h12);
        pin_to(1);
        bus(0, a_ct, 8'h12);
        chk(cpu_irq_o, 0);
        $display("test falling done");
        // rising edge sense
        bus(1, a_ct, 8'h00);
        pin_to(0);
        bus(1, a_ct, 8'h32);
        gap(2);
        bus(1, a_ct, 8'h36);
        gap(1);
        bus(0, a_ct, 8'h32);
        pin_to(1);
        wait_irq();
        bus(0, a_ct, 8'h3A);
        $display("test rising done");
        // edge and level: ack refused while pin low
        bus(1, a_ct, 8'h13);
        bus(1, a_ct, 8'h17);
        gap(2);
        bus(0, a_ct, 8'h13);
        pin_to(0);
        wait_irq();
        bus(1, a_ct, 8'h17);
        gap(2);
        bus(0, a_ct, 8'h1B);
        bus(0, a_st, 8'h03);
        pin_to(1);
        bus(1, a_ct, 8'h17);
        gap(2);
        bus(0, a_ct, 8'h13);
        $display("test level done");
        // status interrupt: masked, unmasked, cleared
        bus(1, a_mk, 8'h00);
        gap(2);
        chk(status_irq_o, 0);
        bus(1, a_mk, 8'h03);
        gap(2);
        chk(status_irq_o, 1);
        bus(1, a_st, 8'h03);
        gap(2);
        chk(status_irq_o, 0);
        bus(0, a_st, 8'h00);
        bus(0, a_mk, 8'h03);
        $display("test status done");
        // polling only, pull release, unmapped place
        bus(1, a_ct, 8'h10);
        gap(1);
        pin_to(0);
        chk(cpu_irq_o, 0);
        @(posedge clk);
        drv_en <= 1'b0;
        gap(6);
        chk(pin, 1);
        bus(1, 4'hF, eirq_byte_t'($urandom));
        bus(0, 4'hF, 8'h00);
        bus(0, a_ct, 8'h18);
        gap(3);
        $display("test polling done");
        // reset in mid-run: everything back to the reset state
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        gap(1);
        chk(cpu_irq_o | pull_en_o | pull_down_o | status_irq_o, 0);
        bus(0, a_ct, `EIRQ_CTRL_RESET);
        gap(2);
        $display("test reset done");
        report_and_stop;
    end
endmodule // eirq_pin_logic_tb

// ==== sim/eirq_pin_model.sv ====
// behavioural external device driving the irq request pin
`timescale 1ns/100ps

module eirq_pin_model
(
    input  wire logic core_clk_i,  // bench clock
    input  wire logic drive_en_i,  // device drives the pin
    input  wire logic drive_val_i, // level while driving
    input  wire logic pull_en_i,   // block's pull resistor on
    input  wire logic pull_down_i, // block's pull is a pulldown
    output logic      pin_o        // resulting pin level
);
    logic last_reg; // last driven level

    // ==========================================================
    // pin level
    // released pin goes to the pull level, or the inverse of the
    // last level so that a floating pin never looks like a hold
    always_comb
    begin
        if (drive_en_i)
            pin_o = drive_val_i;
        else if (pull_en_i)
            pin_o = ~pull_down_i;
        else
            pin_o = ~last_reg;
    end

    // remember what was driven
    always_ff @(posedge core_clk_i)
    begin
        if (drive_en_i)
            last_reg <= drive_val_i;
    end
endmodule // eirq_pin_model
